/* File: rtl/trim_pkg.sv */
// constants, carrier types and register map for the user trim register bank
package trim_pkg;
   // ==========================================================
   // bus and field widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int AXES = 3;
   localparam int RAW_W = 14;
   localparam int OFF_W = 5;
   localparam int GAIN_W = 6;
   localparam int OFF_SIGN_BIT = 4;
   localparam int GAIN_SIGN_BIT = 5;
   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [5:0] IDX_FIRST_ZERO = 6'h33;
   localparam logic [5:0] IDX_SECOND_ZERO = 6'h34;
   localparam logic [5:0] IDX_THIRD_ZERO = 6'h35;
   localparam logic [5:0] IDX_FIRST_GAIN = 6'h36;
   localparam logic [5:0] IDX_SECOND_GAIN = 6'h37;
   localparam logic [5:0] IDX_THIRD_GAIN = 6'h38;
   localparam int IDX_LSB = 2;
   localparam logic [OFF_W-1:0] OFF_RESET = 5'h00;
   localparam logic [GAIN_W-1:0] GAIN_RESET = 6'h00;
   // ==========================================================
   // trim scaling
   localparam int RAW_LSB_UG = 250;
   localparam int OFF_STEP_UG = 15000;
   localparam int OFF_STEP_LSB = OFF_STEP_UG / RAW_LSB_UG;
   // 1.56 % per count is taken as 1/64 of unity gain
   localparam int GAIN_FRAC_BITS = 6;
   localparam int GAIN_UNITY = 2 ** GAIN_FRAC_BITS;
   localparam int OFF_MIN = -(2 ** OFF_SIGN_BIT);
   localparam int OFF_MAX = (2 ** OFF_SIGN_BIT) - 1;
   localparam int GAIN_MIN = -(2 ** GAIN_SIGN_BIT);
   localparam int GAIN_MAX = (2 ** GAIN_SIGN_BIT) - 1;
   localparam int RAW_MIN = -(2 ** (RAW_W - 1));
   localparam int RAW_MAX = (2 ** (RAW_W - 1)) - 1;
   // ==========================================================
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic valid;
      logic [AXES-1:0][RAW_W-1:0] data;
   } sample_t;
   typedef logic [AXES-1:0][OFF_W-1:0] off_set_t;
   typedef logic [AXES-1:0][GAIN_W-1:0] gain_set_t;
endpackage

/* File: rtl/axis_trim_apply.sv */
// one axis of trim correction: shared-range sums, gain scaling, offset shift
module axis_trim_apply
   import trim_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // raw sample
   input wire logic in_valid,
   input wire logic [RAW_W-1:0] in_data,
   // user and factory trims
   input wire logic [OFF_W-1:0] user_off,
   input wire logic [OFF_W-1:0] fac_off,
   input wire logic [GAIN_W-1:0] user_gain,
   input wire logic [GAIN_W-1:0] fac_gain,
   // corrected sample
   output logic out_valid,
   output logic [RAW_W-1:0] out_data
);
   typedef struct packed {
      logic valid;
      logic [RAW_W-1:0] data;
   } apply_state_t;

   apply_state_t st_r;
   apply_state_t st_nxt;

   function automatic int clamp(input int v, input int lo, input int hi);
      int r;
      r = v;
      if (v < lo) begin
         r = lo;
      end else if (v > hi) begin
         r = hi;
      end
      return r;
   endfunction

   // ==========================================================
   // correction
   always_comb begin
      int off_t;
      int gain_t;
      int scaled;
      int sum;
      off_t = 0;
      gain_t = 0;
      scaled = 0;
      sum = 0;
      st_nxt = st_r;
      // user and factory trims share one range
      off_t = clamp(int'($signed(user_off)) + int'($signed(fac_off)), OFF_MIN, OFF_MAX);
      gain_t = clamp(int'($signed(user_gain)) + int'($signed(fac_gain)), GAIN_MIN, GAIN_MAX);
      scaled = (int'($signed(in_data)) * (GAIN_UNITY + gain_t)) >>> GAIN_FRAC_BITS;
      sum = clamp(scaled + off_t * OFF_STEP_LSB, RAW_MIN, RAW_MAX);
      st_nxt.valid = in_valid;
      if (in_valid) begin
         st_nxt.data = RAW_W'(sum);
      end
   end

   always_ff @(posedge aclk) begin
      st_r <= aresetn ? st_nxt : '0;
   end

   assign out_valid = st_r.valid;
   assign out_data = st_r.data;
endmodule

/* File: rtl/axis_user_trim_regs.sv */
// user offset and gain trim register bank with AXI4-Lite access and trim datapath
// ==========================================================
// Summary of operation
// - The first-axis offset trim is a signed five-bit count shifting that axis by 15 mg each.
// - The second-axis offset trim is a signed five-bit count shifting that axis by 15 mg each.
// - The third-axis offset trim is a signed five-bit count shifting that axis by 15 mg each.
// - The first-axis gain trim is a signed six-bit count scaling gain by 1.56 % each.
// - The second-axis gain trim is a signed six-bit count scaling gain by 1.56 % each.
// - Each user offset trim adds to the factory offset trim inside one saturating range.
// - Each user gain trim adds to the factory gain trim inside one saturating range.
// - All offset and gain trim registers read zero after reset.
// - A third-axis six-bit signed gain trim scales that axis by 1.56 % per count.
//
// The AXI4-Lite register port is this design's own decision.
module axis_user_trim_regs
   import trim_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // factory trims
   input wire off_set_t fac_off,
   input wire gain_set_t fac_gain,
   // samples
   input wire sample_t sample_in,
   output sample_t sample_out
);
   typedef struct packed {
      off_set_t off;
      gain_set_t gain;
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [7:0] w_data;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } regs_state_t;

   regs_state_t st_r;
   regs_state_t st_nxt;
   logic [AXES-1:0] valid_vec;
   logic [AXES-1:0][RAW_W-1:0] data_vec;

   // ==========================================================
   // address decode: 0..2 offset of axis, 3..5 gain of axis, -1 unmapped
   function automatic int decode(input logic [ADDR_W-1:0] a);
      logic [5:0] idx;
      int r;
      idx = a[ADDR_W-1:IDX_LSB];
      r = -1;
      unique case (idx)
         IDX_FIRST_ZERO: r = 0;
         IDX_SECOND_ZERO: r = 1;
         IDX_THIRD_ZERO: r = 2;
         IDX_FIRST_GAIN: r = AXES;
         IDX_SECOND_GAIN: r = AXES + 1;
         IDX_THIRD_GAIN: r = AXES + 2;
         default: r = -1;
      endcase
      return r;
   endfunction

   // ==========================================================
   // register file and bus slave
   always_comb begin
      int wsel;
      int rsel;
      wsel = decode(st_r.aw_addr);
      rsel = decode(araddr);
      st_nxt = st_r;
      if (awvalid && st_r.awready) begin
         st_nxt.aw_have = 1'b1;
         st_nxt.aw_addr = awaddr;
      end
      if (wvalid && st_r.wready) begin
         st_nxt.w_have = 1'b1;
         st_nxt.w_data = wdata[7:0];
         st_nxt.w_lane0 = wstrb[0];
      end
      if (st_r.bvalid && bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_have && st_r.w_have && !st_r.bvalid) begin
         for (int a = 0; a < AXES; a++) begin
            if (st_r.w_lane0 && wsel == a) begin
               st_nxt.off[a] = st_r.w_data[OFF_W-1:0];
            end
            if (st_r.w_lane0 && wsel == AXES + a) begin
               st_nxt.gain[a] = st_r.w_data[GAIN_W-1:0];
            end
         end
         st_nxt.aw_have = 1'b0;
         st_nxt.w_have = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = (wsel < 0) ? RESP_SLVERR : RESP_OKAY;
      end
      if (st_r.rvalid && rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (arvalid && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = '0;
         st_nxt.rresp = (rsel < 0) ? RESP_SLVERR : RESP_OKAY;
         for (int a = 0; a < AXES; a++) begin
            if (rsel == a) begin
               st_nxt.rdata = {{(DATA_W-OFF_W){1'b0}}, st_r.off[a]};
            end
            if (rsel == AXES + a) begin
               st_nxt.rdata = {{(DATA_W-GAIN_W){1'b0}}, st_r.gain[a]};
            end
         end
      end
      st_nxt.awready = !st_nxt.aw_have && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.w_have && !st_nxt.bvalid;
      st_nxt.arready = !st_nxt.rvalid;
   end

   // reset clears every trim to zero
   always_ff @(posedge aclk) begin
      st_r <= aresetn ? st_nxt : '0;
   end

   assign awready = st_r.awready;
   assign wready = st_r.wready;
   assign bvalid = st_r.bvalid;
   assign bresp = st_r.bresp;
   assign arready = st_r.arready;
   assign rvalid = st_r.rvalid;
   assign rdata = st_r.rdata;
   assign rresp = st_r.rresp;

   // ==========================================================
   // per-axis trim datapath
   for (genvar g = 0; g < AXES; g++) begin : g_axis
      axis_trim_apply u_apply (
         .aclk(aclk),
         .aresetn(aresetn),
         .in_valid(sample_in.valid),
         .in_data(sample_in.data[g]),
         .user_off(st_r.off[g]),
         .fac_off(fac_off[g]),
         .user_gain(st_r.gain[g]),
         .fac_gain(fac_gain[g]),
         .out_valid(valid_vec[g]),
         .out_data(data_vec[g])
      );
   end

   assign sample_out.valid = &valid_vec;
   assign sample_out.data = data_vec;

   // ==========================================================
   // checks
   function automatic int soff(input logic [OFF_W-1:0] v);
      return int'($signed(v));
   endfunction

   function automatic int sgain(input logic [GAIN_W-1:0] v);
      return int'($signed(v));
   endfunction

   function automatic int sraw(input logic [RAW_W-1:0] v);
      return int'($signed(v));
   endfunction

   sequence quiet_gain_s(int a);
      sample_in.valid && st_r.gain[a] == '0 && fac_gain[a] == '0
         && sraw(sample_in.data[a]) > -2048 && sraw(sample_in.data[a]) < 2048;
   endsequence

   sequence quiet_off_s(int a);
      sample_in.valid && st_r.off[a] == '0 && fac_off[a] == '0
         && sraw(sample_in.data[a]) > -2048 && sraw(sample_in.data[a]) < 2048;
   endsequence

   property off_step_p(int a);
      @(posedge aclk) disable iff (!aresetn)
      quiet_gain_s(a) ##0 (soff(st_r.off[a]) + soff(fac_off[a]) <= OFF_MAX
         && soff(st_r.off[a]) + soff(fac_off[a]) >= OFF_MIN)
      |=> sraw(sample_out.data[a]) == sraw($past(sample_in.data[a]))
         + OFF_STEP_LSB * (soff($past(st_r.off[a])) + soff($past(fac_off[a])));
   endproperty

   property gain_step_p(int a);
      @(posedge aclk) disable iff (!aresetn)
      quiet_off_s(a) ##0 (sgain(st_r.gain[a]) + sgain(fac_gain[a]) <= GAIN_MAX
         && sgain(st_r.gain[a]) + sgain(fac_gain[a]) >= GAIN_MIN)
      |=> sraw(sample_out.data[a]) == ((sraw($past(sample_in.data[a]))
         * (GAIN_UNITY + sgain($past(st_r.gain[a])) + sgain($past(fac_gain[a]))))
         >>> GAIN_FRAC_BITS);
   endproperty

   first_offset_a: assert property (off_step_p(0)) else $error("first axis offset wrong");
   second_offset_a: assert property (off_step_p(1)) else $error("second axis offset wrong");
   third_offset_a: assert property (off_step_p(2)) else $error("third axis offset wrong");
   first_gain_a: assert property (gain_step_p(0)) else $error("first axis gain wrong");
   second_gain_a: assert property (gain_step_p(1)) else $error("second axis gain wrong");
   third_gain_a: assert property (gain_step_p(2)) else $error("third axis gain wrong");

   offset_headroom_a: assert property (@(posedge aclk) disable iff (!aresetn)
      quiet_gain_s(0) ##0 (soff(st_r.off[0]) + soff(fac_off[0]) > OFF_MAX)
      |=> sraw(sample_out.data[0]) == sraw($past(sample_in.data[0])) + OFF_MAX * OFF_STEP_LSB)
      else $error("offset headroom not shared");

   gain_headroom_a: assert property (@(posedge aclk) disable iff (!aresetn)
      quiet_off_s(0) ##0 (sgain(st_r.gain[0]) + sgain(fac_gain[0]) < GAIN_MIN)
      |=> sraw(sample_out.data[0]) == ((sraw($past(sample_in.data[0]))
         * (GAIN_UNITY + GAIN_MIN)) >>> GAIN_FRAC_BITS))
      else $error("gain headroom not shared");

   trims_reset_a: assert property (@(posedge aclk)
      $rose(aresetn) |-> st_r.off == '0 && st_r.gain == '0 && !bvalid && !rvalid)
      else $error("trims not zero after reset");

   upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid |-> rdata[DATA_W-1:GAIN_W] == '0)
      else $error("unused read bits not zero");

   write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (awvalid && awready && wvalid && wready) |-> ##2 (bvalid && $stable(st_r.aw_have) == 0))
      else $error("write response late");

   read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (arvalid && arready) |=> rvalid && !arready)
      else $error("read response late");

   // ==========================================================
   // bus checks
   sequence write_commit_s;
      st_r.aw_have && st_r.w_have && !st_r.bvalid;
   endsequence

   sequence read_take_s;
      arvalid && arready;
   endsequence

   busy_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid |-> !awready && !wready)
      else $error("write accepted while response pending");

   read_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid |-> !arready)
      else $error("read accepted while data pending");

   write_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid && bready |=> awready && wready && !bvalid)
      else $error("write channels not reopened");

   read_ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid && rready |=> arready && !rvalid)
      else $error("read channel not reopened");

   off_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
      write_commit_s ##0 (st_r.w_lane0 && decode(st_r.aw_addr) == 0)
      |=> st_r.off[0] == $past(st_r.w_data[OFF_W-1:0]) && $stable(st_r.gain))
      else $error("offset trim store wrong");

   gain_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
      write_commit_s ##0 (st_r.w_lane0 && decode(st_r.aw_addr) == AXES)
      |=> st_r.gain[0] == $past(st_r.w_data[GAIN_W-1:0]) && $stable(st_r.off))
      else $error("gain trim store wrong");

   lane_guard_a: assert property (@(posedge aclk) disable iff (!aresetn)
      write_commit_s ##0 !st_r.w_lane0 |=> $stable(st_r.off) && $stable(st_r.gain))
      else $error("write without lane zero changed a trim");

   unmapped_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      write_commit_s ##0 (decode(st_r.aw_addr) < 0)
      |=> bvalid && bresp == RESP_SLVERR && $stable(st_r.off) && $stable(st_r.gain))
      else $error("unmapped write not refused");

   unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      read_take_s ##0 (decode(araddr) < 0) |=> rresp == RESP_SLVERR && rdata == '0)
      else $error("unmapped read not refused");

   offset_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      read_take_s ##0 (decode(araddr) >= 0 && decode(araddr) < AXES)
      |=> rdata[DATA_W-1:OFF_W] == '0 && rresp == RESP_OKAY)
      else $error("offset read upper bits not zero");

   gain_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      read_take_s ##0 (decode(araddr) >= AXES)
      |=> rdata[DATA_W-1:GAIN_W] == '0 && rresp == RESP_OKAY)
      else $error("gain read upper bits not zero");

   sample_valid_a: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_out.valid == $past(sample_in.valid))
      else $error("sample valid not delayed by one cycle");

   sample_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !sample_in.valid |=> $stable(sample_out.data))
      else $error("sample data changed without valid");
endmodule

/* File: verif/testbench.sv */
// self-checking testbench for the user trim register bank
module testbench
   import trim_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // clock, reset and ports
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic [DATA_W-1:0] rdata;
   logic [3:0] wstrb = '0;
   logic [1:0] bresp, rresp;
   off_set_t fac_off = '0;
   gain_set_t fac_gain = '0;
   sample_t sample_in = '0;
   sample_t sample_out;
   int mismatches = 0;
   int num_checks = 0;
   int tu[6];
   always #50 aclk = ~aclk;
   axis_user_trim_regs DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .fac_off(fac_off), .fac_gain(fac_gain),
      .sample_in(sample_in), .sample_out(sample_out));
   // ==========================================================
   // reporting
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask
   task automatic tmo(input int n);
      if (n > 50) begin
         $display("Error handshake expected answer seen none");
         mismatches++;
         final_report();
      end
   endtask
   // ==========================================================
   // bus master
   function automatic logic [7:0] reg_addr(input int r);
      return {IDX_FIRST_ZERO + 6'(r), 2'b00};
   endfunction
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            output logic [1:0] resp);
      int n;
      logic ah, wh, bh;
      @(posedge aclk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
      n = 0;
      bh = 1'b0;
      while (!bh) begin
         @(negedge aclk);
         ah = awvalid && awready;
         wh = wvalid && wready;
         bh = bvalid;
         resp = bresp;
         @(posedge aclk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
         if (bh) bready <= 1'b0;
         n++;
         tmo(n);
      end
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      int n;
      logic h;
      @(posedge aclk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      n = 0;
      h = 1'b0;
      while (!h) begin
         @(negedge aclk);
         h = arvalid && arready;
         @(posedge aclk);
         if (h) arvalid <= 1'b0;
         n++;
         tmo(n);
      end
      h = 1'b0;
      while (!h) begin
         @(negedge aclk);
         h = rvalid;
         d = rdata;
         resp = rresp;
         @(posedge aclk);
         if (h) rready <= 1'b0;
         n++;
         tmo(n);
      end
   endtask
   task automatic set_trim(input int r, input int v);
      logic [1:0] rsp;
      axi_write(reg_addr(r), 32'(v), 4'hF, rsp);
      tu[r] = v;
   endtask
   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (tu[i]) tu[i] = 0;
      @(posedge aclk);
   endtask
   // ==========================================================
   // expected sample from trims, shared range and saturation
   function automatic int sat(input int v, input int lo, input int hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction
   function automatic logic [13:0] expect_axis(input int raw, input int i);
      int o, g;
      o = sat(tu[i] + int'($signed(fac_off[i])), OFF_MIN, OFF_MAX);
      g = sat(tu[i+3] + int'($signed(fac_gain[i])), GAIN_MIN, GAIN_MAX);
      return 14'(sat(((raw * (GAIN_UNITY + g)) >>> GAIN_FRAC_BITS) + OFF_STEP_LSB * o,
                     RAW_MIN, RAW_MAX));
   endfunction
   task automatic sample_chk(input int raw);
      @(posedge aclk);
      sample_in.valid <= 1'b1;
      for (int i = 0; i < AXES; i++) sample_in.data[i] <= 14'(raw);
      @(posedge aclk);
      sample_in.valid <= 1'b0;
      #1;
      check("sample valid", 32'h1, 32'(sample_out.valid));
      for (int i = 0; i < AXES; i++) begin
         check($sformatf("axis %0d", i), 32'(expect_axis(raw, i)), 32'(sample_out.data[i]));
      end
   endtask
   // ==========================================================
   // scenarios
   task automatic test_reset_values();
      logic [31:0] d;
      logic [1:0] rsp;
      for (int r = 0; r < 6; r++) begin
         axi_read(reg_addr(r), d, rsp);
         check("trim after reset", 32'h0, d);
         check("rresp", 32'(RESP_OKAY), 32'(rsp));
      end
   endtask
   task automatic test_reserved_bits();
      logic [31:0] d;
      logic [1:0] rsp;
      for (int r = 0; r < 6; r++) begin
         axi_write(reg_addr(r), 32'hFFFFFFFF, 4'hF, rsp);
         check("bresp mapped", 32'(RESP_OKAY), 32'(rsp));
         axi_read(reg_addr(r), d, rsp);
         check("trim field", (r < 3) ? 32'h1F : 32'h3F, d);
      end
      axi_write(reg_addr(0), 32'h00000000, 4'hE, rsp);
      axi_read(reg_addr(0), d, rsp);
      check("lane zero off", 32'h1F, d);
      axi_write(8'hE4, 32'h00000005, 4'hF, rsp);
      check("bresp unmapped", 32'(RESP_SLVERR), 32'(rsp));
      axi_read(8'h40, d, rsp);
      check("rdata unmapped", 32'h0, d);
      check("rresp unmapped", 32'(RESP_SLVERR), 32'(rsp));
   endtask
   task automatic test_offsets();
      for (int a = 0; a < AXES; a++) begin
         set_trim(a, -3);
         sample_chk(100);
         set_trim(a, 15);
         sample_chk(-100);
         set_trim(a, 0);
      end
   endtask
   task automatic test_gains();
      for (int a = 0; a < AXES; a++) begin
         set_trim(a + 3, -32);
         sample_chk(1000);
         set_trim(a + 3, 31);
         sample_chk(-1000);
         set_trim(a + 3, 0);
      end
   endtask
   task automatic test_shared_range();
      // offset headroom with gains at zero, then with gain headroom added at 31 on top
      @(posedge aclk);
      fac_off <= {3{5'h0F}};
      set_trim(0, 15);
      sample_chk(1000);
      set_trim(3, 31);
      @(posedge aclk);
      fac_gain <= {3{6'h1F}};
      sample_chk(8000);
      // gain headroom with offsets at zero, then with negative offset headroom added
      set_trim(0, 0);
      set_trim(3, -32);
      @(posedge aclk);
      fac_off <= '0;
      fac_gain <= {3{6'h20}};
      sample_chk(1000);
      @(posedge aclk);
      fac_off <= {3{5'h10}};
      set_trim(1, -16);
      set_trim(4, -32);
      sample_chk(1000);
   endtask
   initial begin
      do_reset();
      test_reset_values();
      test_reserved_bits();
      do_reset();
      test_reset_values();
      test_offsets();
      test_gains();
      test_shared_range();
      final_report();
   end
endmodule
